// ==== core/fco_core.sv ====
/*
  Receive and transmit 16-bit checksum offload engines with APB control.
  Assumes the MAC marks FCS bytes and the frame's last byte, that the
  receive FIFO always accepts, and that the host stream delivers the
  preamble DWORD first, low byte first, with command flags as sidebands.
*/
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module fco_core import fco_pkg::*; #(
	parameter int TX_BUF_BYTES = 2048
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rx_in_valid,
	input  wire logic [7:0]  rx_in_data,
	input  wire logic        rx_in_fcs,
	input  wire logic        rx_in_last,
	output logic             rx_in_ready,
	input  wire logic        rx_stat_valid,
	input  wire logic [31:0] rx_stat_data,
	output logic             rx_stat_ready,
	output logic             rx_out_valid,
	output logic      [7:0]  rx_out_data,
	output logic             rx_out_last,
	output logic             rx_out_stat_valid,
	output logic      [31:0] rx_out_stat_data,
	input  wire logic        tx_in_valid,
	input  wire logic [7:0]  tx_in_data,
	input  wire logic        tx_in_last,
	input  wire logic        tx_in_first_seg,
	input  wire logic        tx_in_sum_req,
	output logic             tx_in_ready,
	output logic             tx_out_valid,
	output logic      [7:0]  tx_out_data,
	output logic             tx_out_last,
	input  wire logic        tx_out_ready
);
	localparam int AW = $clog2(TX_BUF_BYTES);

	// All checks run on the bus clock and rest while reset is held
	default clocking fco_cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Buffer index must stay a power of two within the 12-bit offsets
	if (TX_BUF_BYTES < 64 || TX_BUF_BYTES > 4096 || (1 << AW) != TX_BUF_BYTES) begin : g_chk
		$error("TX_BUF_BYTES must be a power of two from 64 to 4096");
	end

	// End-around-carry add of two 16-bit terms
	function automatic logic [15:0] fco_fold(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[15:0] + {15'h0000, s[16]};
	endfunction

	logic             rx_sum_enable, rx_sum_mode, tx_sum_enable, tx_sum_mode;
	logic      [15:0] vlan_type, rx_last_sum, tx_last_sum;
	logic      [31:0] ctrl_word;
	logic             apb_write, addr_hit;
	fco_rx_state_type rx_state;
	logic      [11:0] rx_cnt, rx_type_pos, rx_start, rx_start_eff;
	logic      [1:0]  rx_tags;
	logic      [7:0]  rx_type_hi, rx_low;
	logic             rx_found, rx_found_eff, rx_half, rx_take, rx_add;
	logic      [15:0] rx_sum, rx_final, rx_type_val;
	logic      [13:0] rx_stat_len;
	fco_tx_state_type tx_state;
	logic      [31:0] tx_pre;
	logic      [1:0]  tx_pre_cnt;
	logic             tx_do_sum, tx_half, tx_take, tx_add, tx_load, tx_wr_en;
	logic      [12:0] tx_wr, tx_rd, tx_len, tx_loc;
	logic      [7:0]  tx_buf [TX_BUF_BYTES];
	logic      [7:0]  tx_low, tx_rd_byte, tx_out_byte;
	logic      [15:0] tx_sum, tx_raw, tx_result;

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	// Zero wait states; unmapped addresses answer with pslverr
	assign pready    = 1'b1;
	assign apb_write = psel && penable && pwrite;
	assign addr_hit  = paddr == FCO_CTRL_ADDR || paddr == FCO_VLAN_ADDR ||
	                   paddr == FCO_STAT_ADDR || paddr == FCO_SUMS_ADDR;
	assign pslverr   = psel && penable && !addr_hit;

	// Control bits; software must flush a path before changing them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_sum_enable <= FCO_CTRL_RESET;
			rx_sum_mode   <= FCO_CTRL_RESET;
			tx_sum_enable <= FCO_CTRL_RESET;
			tx_sum_mode   <= FCO_CTRL_RESET;
		end else if (apb_write && paddr == FCO_CTRL_ADDR) begin
			rx_sum_enable <= pwdata[FCO_RX_EN_BIT];
			rx_sum_mode   <= pwdata[FCO_RX_MD_BIT];
			tx_sum_enable <= pwdata[FCO_TX_EN_BIT];
			tx_sum_mode   <= pwdata[FCO_TX_MD_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			vlan_type <= FCO_VLAN_RESET;
		else if (apb_write && paddr == FCO_VLAN_ADDR)
			vlan_type <= pwdata[15:0];
	end

	always_comb begin
		ctrl_word                = 32'h00000000;
		ctrl_word[FCO_RX_EN_BIT] = rx_sum_enable;
		ctrl_word[FCO_RX_MD_BIT] = rx_sum_mode;
		ctrl_word[FCO_TX_EN_BIT] = tx_sum_enable;
		ctrl_word[FCO_TX_MD_BIT] = tx_sum_mode;
	end

	// Read data is latched in the setup phase so it stands in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (psel && !penable && !pwrite) begin
			case (paddr)
				FCO_CTRL_ADDR: prdata <= ctrl_word;
				FCO_VLAN_ADDR: prdata <= {16'h0000, vlan_type};
				FCO_STAT_ADDR: prdata <= {30'h00000000, tx_state != FCO_TX_IDLE,
				                          rx_state != FCO_RX_PASS};
				FCO_SUMS_ADDR: prdata <= {tx_last_sum, rx_last_sum};
				default:       prdata <= 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Receive engine
	// ----------------------------------------------------------------
	// Input stalls only for the two appended bytes
	assign rx_in_ready   = rx_state == FCO_RX_PASS;
	assign rx_stat_ready = rx_in_ready;
	assign rx_take       = rx_in_valid && rx_in_ready;
	// mode 0 fixed start, mode 1 parsed start
	assign rx_found_eff  = !rx_sum_mode || rx_found;
	assign rx_start_eff  = rx_sum_mode ? rx_start : FCO_HDR_BYTES;
	// FCS bytes never summed, pads are
	assign rx_add        = rx_take && rx_sum_enable && rx_found_eff &&
	                       rx_cnt >= rx_start_eff && !rx_in_fcs;
	assign rx_type_val   = {rx_type_hi, rx_in_data};
	// odd trailing byte paired with zero
	assign rx_final      = rx_half ? fco_fold(rx_sum, {8'h00, rx_low}) : rx_sum;
	assign rx_stat_len   = rx_stat_data[FCO_LEN_MSB:FCO_LEN_LSB];

	// Byte position in frame, saturating so giant frames never wrap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rx_cnt <= 12'h000;
		else if (rx_take)
			rx_cnt <= rx_in_last ? 12'h000 : (rx_cnt == 12'hFFF ? rx_cnt : rx_cnt + 12'h001);
	end

	// header walk, tags followed at most twice
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_found    <= 1'b0;
			rx_type_pos <= FCO_TYPE_POS;
			rx_tags     <= 2'h0;
			rx_start    <= FCO_HDR_BYTES;
			rx_type_hi  <= 8'h00;
		end else if (rx_take && rx_in_last) begin
			rx_found    <= 1'b0;
			rx_type_pos <= FCO_TYPE_POS;
			rx_tags     <= 2'h0;
			rx_start    <= FCO_HDR_BYTES;
		end else if (rx_take && !rx_found) begin
			if (rx_cnt == rx_type_pos)
				rx_type_hi <= rx_in_data;
			if (rx_cnt == rx_type_pos + 12'h001) begin
				if (rx_type_val == vlan_type && rx_tags < FCO_MAX_TAGS) begin
					rx_type_pos <= rx_type_pos + FCO_TAG_BYTES;
					rx_tags     <= rx_tags + 2'h1;
				end else begin
					// a length field means a SNAP header follows
					rx_found <= 1'b1;
					rx_start <= (rx_type_val < FCO_MIN_ETYPE) ?
					            rx_type_pos + FCO_TYPE_BYTES + FCO_SNAP_BYTES :
					            rx_type_pos + FCO_TYPE_BYTES;
				end
			end
		end
	end

	// first byte low, second high, carry folded
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_sum  <= 16'h0000;
			rx_half <= 1'b0;
			rx_low  <= 8'h00;
		end else if (rx_state == FCO_RX_APP_HI) begin
			rx_sum  <= 16'h0000;
			rx_half <= 1'b0;
		end else if (rx_add) begin
			rx_low  <= rx_in_data;
			rx_half <= !rx_half;
			if (rx_half)
				rx_sum <= fco_fold(rx_sum, {rx_in_data, rx_low});
		end
	end

	// every frame ends in the append sequence while enabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rx_state <= FCO_RX_PASS;
		else begin
			case (rx_state)
				FCO_RX_PASS:   if (rx_take && rx_in_last && rx_sum_enable) rx_state <= FCO_RX_APP_LO;
				FCO_RX_APP_LO: rx_state <= FCO_RX_APP_HI;
				default:       rx_state <= FCO_RX_PASS;
			endcase
		end
	end

	// checksum bytes follow the frame, low byte first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_out_valid <= 1'b0;
			rx_out_data  <= 8'h00;
			rx_out_last  <= 1'b0;
		end else begin
			rx_out_valid <= rx_take || rx_state != FCO_RX_PASS;
			rx_out_data  <= rx_state == FCO_RX_APP_LO ? rx_final[7:0] :
			                rx_state == FCO_RX_APP_HI ? rx_final[15:8] : rx_in_data;
			rx_out_last  <= rx_state == FCO_RX_APP_HI ||
			                (rx_take && rx_in_last && !rx_sum_enable);
		end
	end

	// Last appended checksum, kept for software readback
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rx_last_sum <= 16'h0000;
		else if (rx_state == FCO_RX_APP_LO)
			rx_last_sum <= rx_final;
	end

	// status length grows by the two appended bytes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_out_stat_valid <= 1'b0;
			rx_out_stat_data  <= 32'h00000000;
		end else begin
			rx_out_stat_valid <= rx_stat_valid && rx_stat_ready;
			rx_out_stat_data  <= rx_stat_data;
			if (rx_sum_enable)
				rx_out_stat_data[FCO_LEN_MSB:FCO_LEN_LSB] <= rx_stat_len + FCO_LEN_ADD;
		end
	end

	// ----------------------------------------------------------------
	// Transmit engine
	// ----------------------------------------------------------------
	// Store and forward: the result lands before the end of the summed span
	assign tx_in_ready = tx_state == FCO_TX_PRE || tx_state == FCO_TX_FILL;
	assign tx_take     = tx_in_valid && tx_in_ready;
	assign tx_wr_en    = tx_take && tx_state == FCO_TX_FILL && tx_wr < 13'(TX_BUF_BYTES);
	// summing from the start offset to the end
	assign tx_add      = tx_take && tx_state == FCO_TX_FILL && tx_do_sum &&
	                     tx_wr >= {1'b0, tx_pre[FCO_START_MSB:0]};
	assign tx_raw      = tx_half ? fco_fold(tx_sum, {8'h00, tx_low}) : tx_sum;
	// complement inserted; zero becomes all ones
	assign tx_result   = (tx_pre[FCO_FIX_BIT] && ~tx_raw == 16'h0000) ? 16'hFFFF : ~tx_raw;
	// only the defined preamble fields are decoded
	assign tx_loc      = {1'b0, tx_pre[FCO_LOC_MSB:FCO_LOC_LSB]};
	assign tx_load     = tx_state == FCO_TX_DRAIN && (!tx_out_valid || tx_out_ready) &&
	                     tx_rd < tx_len;
	assign tx_rd_byte  = tx_buf[tx_rd[AW-1:0]];

	// result overwrites two bytes at the location
	always_comb begin
		tx_out_byte = tx_rd_byte;
		if (tx_do_sum && tx_rd == tx_loc)
			tx_out_byte = tx_result[7:0];
		else if (tx_do_sum && tx_rd == tx_loc + 13'h0001)
			tx_out_byte = tx_result[15:8];
	end

	// all three conditions latched at packet start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tx_do_sum <= 1'b0;
		else if (tx_state == FCO_TX_IDLE && tx_in_valid)
			tx_do_sum <= tx_sum_enable && tx_in_first_seg && tx_in_sum_req;
	end

	// preamble DWORD consumed and not forwarded
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_pre     <= 32'h00000000;
			tx_pre_cnt <= 2'h0;
		end else if (tx_state == FCO_TX_IDLE) begin
			tx_pre     <= 32'h00000000;
			tx_pre_cnt <= 2'h0;
		end else if (tx_take && tx_state == FCO_TX_PRE) begin
			tx_pre     <= {tx_in_data, tx_pre[31:8]};
			tx_pre_cnt <= tx_pre_cnt + 2'h1;
		end
	end

	// A packet that ends inside the preamble is dropped whole
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tx_state <= FCO_TX_IDLE;
		else begin
			case (tx_state)
				FCO_TX_IDLE:
					if (tx_in_valid) tx_state <= tx_sum_enable ? FCO_TX_PRE : FCO_TX_FILL;
				FCO_TX_PRE:
					if (tx_take && tx_in_last) tx_state <= FCO_TX_IDLE;
					else if (tx_take && tx_pre_cnt == FCO_PRE_LAST) tx_state <= FCO_TX_FILL;
				FCO_TX_FILL:
					if (tx_take && tx_in_last) tx_state <= FCO_TX_DRAIN;
				default:
					if ((!tx_out_valid || tx_out_ready) && tx_rd >= tx_len) tx_state <= FCO_TX_IDLE;
			endcase
		end
	end

	// Packet store; bytes beyond the buffer are lost
	always_ff @(posedge pclk) begin
		if (tx_wr_en)
			tx_buf[tx_wr[AW-1:0]] <= tx_in_data;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_wr  <= 13'h0000;
			tx_rd  <= 13'h0000;
			tx_len <= 13'h0000;
		end else if (tx_state == FCO_TX_IDLE) begin
			tx_wr <= 13'h0000;
			tx_rd <= 13'h0000;
		end else if (tx_take && tx_state == FCO_TX_FILL) begin
			tx_wr <= tx_wr + 13'h0001;
			if (tx_in_last)
				tx_len <= tx_wr_en ? tx_wr + 13'h0001 : 13'(TX_BUF_BYTES);
		end else if (tx_load)
			tx_rd <= tx_rd + 13'h0001;
	end

	// Same pairing and carry folding as the receive side
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_sum  <= 16'h0000;
			tx_half <= 1'b0;
			tx_low  <= 8'h00;
		end else if (tx_state == FCO_TX_IDLE) begin
			tx_sum  <= 16'h0000;
			tx_half <= 1'b0;
		end else if (tx_add) begin
			tx_low  <= tx_in_data;
			tx_half <= !tx_half;
			if (tx_half)
				tx_sum <= fco_fold(tx_sum, {tx_in_data, tx_low});
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tx_last_sum <= 16'h0000;
		else if (tx_state == FCO_TX_DRAIN && tx_rd == 13'h0000 && tx_do_sum)
			tx_last_sum <= tx_result;
	end

	// without a sum the stored bytes go out as they came
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_out_valid <= 1'b0;
			tx_out_data  <= 8'h00;
			tx_out_last  <= 1'b0;
		end else if (tx_load) begin
			tx_out_valid <= 1'b1;
			tx_out_data  <= tx_out_byte;
			tx_out_last  <= tx_rd + 13'h0001 == tx_len;
		end else if (tx_out_ready)
			tx_out_valid <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence fco_rx_append_seq;
		rx_state == FCO_RX_APP_LO ##1 rx_state == FCO_RX_APP_HI && rx_out_valid
		##1 rx_out_last && rx_out_data == rx_last_sum[15:8];
	endsequence

	AST_RX_APPEND: assert property (
		rx_take && rx_in_last && rx_sum_enable |=> fco_rx_append_seq)
		else $error("checksum not appended after frame");
	AST_RX_LEN: assert property (
		rx_stat_valid && rx_stat_ready && rx_sum_enable |=> rx_out_stat_valid &&
		rx_out_stat_data[FCO_LEN_MSB:FCO_LEN_LSB] == $past(rx_stat_len) + FCO_LEN_ADD)
		else $error("status length not increased by two");
	AST_RX_PASS: assert property (
		rx_take && !rx_sum_enable |=> rx_out_valid && rx_out_data == $past(rx_in_data) &&
		rx_out_last == $past(rx_in_last))
		else $error("disabled receive path altered data");
	AST_RX_MODE0: assert property (
		rx_add && !rx_sum_mode |-> rx_cnt >= FCO_HDR_BYTES)
		else $error("mode 0 summed a header byte");
	AST_RX_NO_FCS: assert property (
		rx_in_fcs |-> !rx_add)
		else $error("FCS byte summed");
	AST_RX_TAGS: assert property (
		rx_take && rx_tags == FCO_MAX_TAGS |=> rx_tags == FCO_MAX_TAGS || rx_tags == 2'h0)
		else $error("more than two tags followed");
	AST_TX_PRE_DROP: assert property (
		tx_state == FCO_TX_PRE |-> !tx_wr_en ##1 !(tx_out_valid && tx_state == FCO_TX_PRE))
		else $error("preamble byte forwarded");
	AST_TX_GATE: assert property (
		tx_add |-> tx_do_sum && tx_sum_enable)
		else $error("transmit sum without request");
	AST_TX_ZERO: assert property (
		tx_state == FCO_TX_DRAIN && tx_pre[FCO_FIX_BIT] |-> tx_result != 16'h0000)
		else $error("zero result not replaced");
	AST_TX_INSERT: assert property (
		tx_load && tx_do_sum && tx_rd == tx_loc |=> tx_out_data == tx_result[7:0])
		else $error("result not inserted at location");
	AST_TX_NO_SUM: assert property (
		tx_load && !tx_do_sum |=> tx_out_data == $past(tx_rd_byte))
		else $error("unsummed packet modified");
endmodule

// ==== core/fco_pkg.sv ====
/*
  Shared constants and types of the frame checksum offload block:
  APB register map, control bit positions, reset values, frame layout
  offsets, status and preamble field positions, engine state types.
  Assumes byte-wide streams and a 32-bit APB register bus.
*/
package fco_pkg;
	// ----------------------------------------------------------------
	// Register map and control fields
	// ----------------------------------------------------------------
	localparam logic [7:0]  FCO_CTRL_ADDR  = 8'h00;
	localparam logic [7:0]  FCO_VLAN_ADDR  = 8'h04;
	localparam logic [7:0]  FCO_STAT_ADDR  = 8'h08;
	localparam logic [7:0]  FCO_SUMS_ADDR  = 8'h0C;
	localparam int          FCO_RX_EN_BIT  = 0;
	localparam int          FCO_RX_MD_BIT  = 1;
	localparam int          FCO_TX_EN_BIT  = 16;
	localparam int          FCO_TX_MD_BIT  = 17;
	localparam logic        FCO_CTRL_RESET = 1'b0;
	localparam logic [15:0] FCO_VLAN_RESET = 16'h8100;
	// ----------------------------------------------------------------
	// Frame layout
	// ----------------------------------------------------------------
	localparam logic [11:0] FCO_HDR_BYTES  = 12'h00E;
	localparam logic [11:0] FCO_TYPE_POS   = 12'h00C;
	localparam logic [11:0] FCO_TAG_BYTES  = 12'h004;
	localparam logic [11:0] FCO_TYPE_BYTES = 12'h002;
	localparam logic [11:0] FCO_SNAP_BYTES = 12'h008;
	localparam logic [1:0]  FCO_MAX_TAGS   = 2'h2;
	localparam logic [15:0] FCO_MIN_ETYPE  = 16'h0600;
	// ----------------------------------------------------------------
	// Status word and preamble fields
	// ----------------------------------------------------------------
	localparam int          FCO_LEN_LSB    = 16;
	localparam int          FCO_LEN_MSB    = 29;
	localparam logic [13:0] FCO_LEN_ADD    = 14'h0002;
	localparam int          FCO_START_MSB  = 11;
	localparam int          FCO_LOC_LSB    = 16;
	localparam int          FCO_LOC_MSB    = 27;
	localparam int          FCO_FIX_BIT    = 31;
	localparam logic [1:0]  FCO_PRE_LAST   = 2'h3;
	// ----------------------------------------------------------------
	// Engine states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {FCO_RX_PASS, FCO_RX_APP_LO, FCO_RX_APP_HI} fco_rx_state_type;
	typedef enum logic [1:0] {FCO_TX_IDLE, FCO_TX_PRE, FCO_TX_FILL, FCO_TX_DRAIN} fco_tx_state_type;
endpackage

// ==== tb/fco_tx_sink.sv ====
/*
  Model of the MAC transmit path that takes bytes from the block.
  Assumes the block holds each output byte until ready is seen high.
*/
`timescale 1ns/1ps
module fco_tx_sink (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       tx_out_valid,
	input  wire logic [7:0] tx_out_data,
	input  wire logic       tx_out_last,
	output logic            tx_out_ready
);
	logic [2:0] stall_count;
	logic [7:0] got[$];
	logic       got_last[$];
	// Ready stalls three cycles in eight, so held bytes get exercised
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stall_count  <= 3'h0;
			tx_out_ready <= 1'b0;
		end else begin
			stall_count  <= stall_count + 3'h1;
			tx_out_ready <= (stall_count < 3'h5);
		end
	end
	// Looked at between edges so the handshake has settled
	always @(negedge pclk) begin
		if (tx_out_valid === 1'b1 && tx_out_ready === 1'b1) begin
			got.push_back(tx_out_data);
			got_last.push_back(tx_out_last);
		end
	end
endmodule

// ==== tb/tb.sv ====
/*
  Testbench of the checksum offload block: APB set-up, receive frames in
  each mode, transmit packets with a preamble into the sink model.
  Assumes the hand-over timing: zero-wait APB, one-cycle receive pulses.
*/
`timescale 1ns/1ps
module tb import fco_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr, rx_in_data, rx_out_data, tx_in_data, tx_out_data;
	logic [31:0] pwdata, prdata, rx_stat_data, rx_out_stat_data, rdata, stat_seen;
	logic rx_in_valid, rx_in_fcs, rx_in_last, rx_in_ready, rx_stat_valid, rx_stat_ready;
	logic rx_out_valid, rx_out_last, rx_out_stat_valid, tx_in_valid, tx_in_last;
	logic tx_in_first_seg, tx_in_sum_req, tx_in_ready, tx_out_valid, tx_out_last;
	logic tx_out_ready, rerr;
	logic [7:0] frm[$], pkt[$], rxq[$];
	logic rxl[$];
	logic [15:0] exp;
	logic [31:0] pre;
	int num_errors, n_tests;
	fco_core #(.TX_BUF_BYTES(64)) fco_core_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rx_in_valid(rx_in_valid), .rx_in_data(rx_in_data),
		.rx_in_fcs(rx_in_fcs), .rx_in_last(rx_in_last), .rx_in_ready(rx_in_ready),
		.rx_stat_valid(rx_stat_valid), .rx_stat_data(rx_stat_data), .rx_stat_ready(rx_stat_ready),
		.rx_out_valid(rx_out_valid), .rx_out_data(rx_out_data), .rx_out_last(rx_out_last),
		.rx_out_stat_valid(rx_out_stat_valid), .rx_out_stat_data(rx_out_stat_data),
		.tx_in_valid(tx_in_valid), .tx_in_data(tx_in_data), .tx_in_last(tx_in_last),
		.tx_in_first_seg(tx_in_first_seg), .tx_in_sum_req(tx_in_sum_req),
		.tx_in_ready(tx_in_ready), .tx_out_valid(tx_out_valid), .tx_out_data(tx_out_data),
		.tx_out_last(tx_out_last), .tx_out_ready(tx_out_ready));
	fco_tx_sink fco_tx_sink_i (.pclk(pclk), .presetn(presetn), .tx_out_valid(tx_out_valid),
		.tx_out_data(tx_out_data), .tx_out_last(tx_out_last), .tx_out_ready(tx_out_ready));
	// ------------------------------------------------------------
	// Clock, watchdog and shared tasks
	// ------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	initial begin
		#400000;
		num_errors++;
		report_and_stop();
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		n_tests++;
		if (got !== want) begin
			num_errors++;
			$display("BAD at %0t: got %h expected %h", $time, got, want);
		end
	endtask
	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Request held until the edge at which ready is sampled high; one idle
	// edge follows, so back-to-back calls never assign a strobe twice at once
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// Byte handed over at the edge where ready is sampled high
	task automatic rx_byte(input logic [7:0] d, input logic f, input logic l);
		rx_in_valid <= 1'b1; rx_in_data <= d; rx_in_fcs <= f; rx_in_last <= l;
		do @(posedge pclk); while (rx_in_ready !== 1'b1);
	endtask
	task automatic tx_byte(input logic [7:0] d, input logic l, input logic r);
		tx_in_valid <= 1'b1; tx_in_data <= d; tx_in_last <= l;
		tx_in_first_seg <= 1'b1; tx_in_sum_req <= r;
		do @(posedge pclk); while (tx_in_ready !== 1'b1);
	endtask
	// Carry folded back after every term, so no end-around step is lost
	function automatic logic [15:0] csum(input logic [7:0] b[$], input int s, input int e);
		logic [31:0] acc;
		acc = 32'h0;
		for (int i = s; i < e; i += 2) begin
			acc = acc + {16'h0, (i + 1 < e) ? b[i + 1] : 8'h00, b[i]};
			acc = {16'h0, acc[15:0]} + {16'h0, acc[31:16]};
		end
		return acc[15:0];
	endfunction
	always @(negedge pclk) begin
		if (rx_out_valid === 1'b1) begin
			rxq.push_back(rx_out_data);
			rxl.push_back(rx_out_last);
		end
		if (rx_out_stat_valid === 1'b1) stat_seen = rx_out_stat_data;
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{rx_in_valid, rx_in_data, rx_in_fcs, rx_in_last, rx_stat_valid, rx_stat_data} = '0;
		{tx_in_valid, tx_in_data, tx_in_last, tx_in_first_seg, tx_in_sum_req} = '0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, FCO_VLAN_ADDR, 32'h0);
		chk(rdata, 32'h8100);
		apb(1'b0, 8'h10, 32'h0);
		chk(rerr, 1'b1);
		// Tagged frame with odd payload: 12 address, tag, type, 7 data, 4 FCS
		for (int k = 0; k < 29; k++) frm.push_back(8'h11 * k[7:0] + 8'h05);
		frm[12] = 8'h81; frm[13] = 8'h00; frm[16] = 8'h08; frm[17] = 8'h00;
		// controls change only between frames; pads stay in
		for (int rc = 0; rc < 4; rc++) begin
			// Last pass stacks three tags, so the third one ends the walk
			if (rc == 3) begin
				frm[16] = 8'h81;
				frm[17] = 8'h00;
				frm[20] = 8'h81;
				frm[21] = 8'h00;
			end
			apb(1'b1, FCO_CTRL_ADDR, (rc == 0) ? 32'h0 : (rc == 1) ? 32'h1 : 32'h3);
			rxq.delete();
			rxl.delete();
			stat_seen = 32'hXXXXXXXX;
			for (int k = 0; k < 29; k++) rx_byte(frm[k], k >= 25, k == 28);
			rx_in_valid <= 1'b0; rx_stat_valid <= 1'b1; rx_stat_data <= 32'h001D0000;
			do @(posedge pclk); while (rx_stat_ready !== 1'b1);
			rx_stat_valid <= 1'b0;
			repeat (6) @(posedge pclk);
			exp = csum(frm, (rc == 1) ? 14 : (rc == 2) ? 18 : 22, 25);
			chk(rxq.size(), (rc == 0) ? 29 : 31);
			chk(stat_seen[29:16], (rc == 0) ? 29 : 31);
			for (int k = 0; k < 29; k++) chk(rxq[k], frm[k]);
			if (rc > 0) begin
				chk({rxq[30], rxq[29]}, exp);
				chk({rxl[30], rxl[28]}, 2'h2);
				apb(1'b0, FCO_SUMS_ADDR, 32'h0);
				chk(rdata[15:0], exp);
			end
		end
		// transmit enable set while both paths stand idle
		apb(1'b1, FCO_CTRL_ADDR, 32'h10000);
		// Second packet sums to FFFF so its complement hits the zero fix;
		// the third asks for no sum and must pass untouched
		for (int pk = 0; pk < 3; pk++) begin
			pkt.delete();
			fco_tx_sink_i.got.delete();
			fco_tx_sink_i.got_last.delete();
			for (int k = 0; k < 24; k++) pkt.push_back((pk == 1) ? 8'h00 : 8'h07 * k[7:0] + 8'h03);
			if (pk == 1) begin
				pkt[14] = 8'hFF; pkt[15] = 8'hFF;
			end
			pkt[16] = 8'h00; pkt[17] = 8'h00;
			exp = (pk == 1) ? 16'hFFFF : ~csum(pkt, 14, 24);
			// preamble DWORD alone ahead of the packet, low byte first
			// start 14 and location 16, clear of header and tail
			// Reserved preamble bits set on the first and third packets
			pre = (pk == 1) ? 32'h8010000E : 32'h7010F00E;
			for (int k = 0; k < 4; k++) tx_byte(pre[k * 8 +: 8], 1'b0, pk != 2);
			for (int k = 0; k < 24; k++) tx_byte(pkt[k], k == 23, pk != 2);
			tx_in_valid <= 1'b0;
			for (int w = 0; w < 300 && fco_tx_sink_i.got.size() < 24; w++) @(posedge pclk);
			if (pk != 2) begin
				pkt[16] = exp[7:0]; pkt[17] = exp[15:8];
			end
			chk(fco_tx_sink_i.got.size(), 24);
			for (int k = 0; k < 24; k++) begin
				chk(fco_tx_sink_i.got[k], pkt[k]);
			end
			chk(fco_tx_sink_i.got_last[23], 1'b1);
		end
		report_and_stop();
	end
endmodule
